/* logic/sspc_pkg.sv */
package sspc_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] WORD_MASK = 12'hffc;
  localparam logic [11:0] OFF_CONTROL_ZERO = 12'h000;
  localparam logic [11:0] OFF_CONTROL_ONE = 12'h004;
  localparam logic [11:0] OFF_FIFO_DATA_PORT = 12'h008;
  localparam logic [11:0] OFF_PORT_STATUS = 12'h00c;
  localparam logic [11:0] OFF_CLOCK_PRESCALE = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
  localparam logic [11:0] OFF_IRQ_RAW_STATUS = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASKED_STATUS = 12'h01c;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h020;

  ////////////////////////////////////////////////////////////////////////////
  localparam int FRAME_MAX = 16;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int CR0_W = 16;
  localparam int SIZE_LSB = 0;
  localparam int SIZE_W = 4;
  localparam int FMT_LSB = 4;
  localparam int FMT_W = 2;
  localparam int IDLE_POL_BIT = 6;
  localparam int PHASE_BIT = 7;
  localparam int SCR_LSB = 8;
  localparam int SCR_W = 8;
  localparam int CR1_W = 3;
  localparam int ENABLE_BIT = 1;
  localparam int SLAVE_BIT = 2;
  localparam int PRESCALE_W = 8;
  localparam int STATUS_W = 5;
  localparam int ST_TX_EMPTY = 0;
  localparam int ST_TX_NOT_FULL = 1;
  localparam int ST_RX_NOT_EMPTY = 2;
  localparam int ST_RX_FULL = 3;
  localparam int ST_BUSY = 4;
  localparam int IRQ_W = 4;
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_TIMEOUT = 1;
  localparam int IRQ_RX_HALF = 2;
  localparam int IRQ_TX_HALF = 3;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] CR0_RESET = 16'h0000;
  localparam logic [2:0] CR1_RESET = 3'h0;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_SSI = 2'h1;
  localparam logic [1:0] FMT_THREE_WIRE = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] SSI_PREFIX_EDGES = 6'h02;

  typedef enum logic [1:0] {
    SSPC_IDLE,
    SSPC_LEAD,
    SSPC_RUN,
    SSPC_TAIL
  } sspc_state_t;

endpackage : sspc_pkg

/* logic/sspc_top.sv */
`timescale 1ns/10ps
module sspc_top #(
  parameter int FIFO_DEPTH = sspc_pkg::FIFO_DEPTH_DEF,
  parameter int FRAME_W = sspc_pkg::FRAME_MAX
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [sspc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [sspc_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic serial_clk_i,
  output logic serial_clk_o,
  output logic serial_clk_oe_o,
  input wire logic frame_sync_line_i,
  output logic frame_sync_line_o,
  output logic frame_sync_line_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o
);

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
  localparam logic [CNT_W-1:0] HALF_C = CNT_W'(FIFO_DEPTH / 2);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(FIFO_DEPTH - 1);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    merge = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction : merge

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == LAST_PTR) ? '0 : p + PTR_W'(1);
  endfunction : bump

  ////////////////////////////////////////////////////////////////////////////
  logic [sspc_pkg::CR0_W-1:0] control_zero, next_control_zero;
  logic [sspc_pkg::CR1_W-1:0] control_one, next_control_one;
  logic [sspc_pkg::PRESCALE_W-1:0] clock_prescale, next_clock_prescale;
  logic [sspc_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
  logic overrun, next_overrun;
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [sspc_pkg::ADDR_W-1:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata, rd_val, wr_val;
  logic rd_hit;
  logic [sspc_pkg::ADDR_W-1:0] wa, ra;

  logic [FRAME_W-1:0] tx_mem [FIFO_DEPTH];
  logic [FRAME_W-1:0] rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  logic tx_push, tx_pop, rx_push, rx_pop, rx_accept;
  logic [FRAME_W-1:0] tx_wdata, rx_wdata;

  sspc_pkg::sspc_state_t state, next_state;
  logic [6:0] pre_cnt, next_pre_cnt, half_end;
  logic [7:0] scr_cnt, next_scr_cnt;
  logic [5:0] edge_cnt, next_edge_cnt, frame_edges, prefix, d_idx;
  logic [FRAME_W-1:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
  logic sclk_q, next_sclk_q, sel_q, next_sel_q, slv_on, next_slv_on;
  logic tick, edge_go, capture_now, in_bit, slv_done, slv_load;

  logic sclk_m, sclk_s, sclk_d, sel_m, sel_s;
  logic mosi_m, mosi_s, miso_m, miso_s;

  logic [3:0] data_size_field;
  logic [1:0] frame_format_field;
  logic [7:0] scr;
  logic is_ssi, clock_idle_polarity, clock_capture_phase;
  logic master_on, slave_mode, busy;
  logic [sspc_pkg::STATUS_W-1:0] status;
  logic [sspc_pkg::IRQ_W-1:0] raw;

  ////////////////////////////////////////////////////////////////////////////
  assign data_size_field =
    control_zero[sspc_pkg::SIZE_LSB +: sspc_pkg::SIZE_W];
  assign frame_format_field =
    control_zero[sspc_pkg::FMT_LSB +: sspc_pkg::FMT_W];
  assign scr = control_zero[sspc_pkg::SCR_LSB +: sspc_pkg::SCR_W];
  assign is_ssi = (frame_format_field == sspc_pkg::FMT_SSI);
  // Outside SPI the clock idles low and, of those formats, only sync serial captures late
  assign clock_idle_polarity = (frame_format_field == sspc_pkg::FMT_SPI) &
    control_zero[sspc_pkg::IDLE_POL_BIT];
  assign clock_capture_phase = (frame_format_field == sspc_pkg::FMT_SPI) ?
    control_zero[sspc_pkg::PHASE_BIT] : is_ssi;
  assign master_on = control_one[sspc_pkg::ENABLE_BIT] &
                     ~control_one[sspc_pkg::SLAVE_BIT];
  assign slave_mode = control_one[sspc_pkg::ENABLE_BIT] &
                      control_one[sspc_pkg::SLAVE_BIT];
  assign frame_edges = ({2'b00, data_size_field} << 1) + 6'h02;
  assign prefix = is_ssi ? sspc_pkg::SSI_PREFIX_EDGES : 6'h00;
  assign d_idx = slave_mode ? edge_cnt : edge_cnt - prefix;
  assign capture_now = (d_idx[0] == clock_capture_phase);
  assign in_bit = slave_mode ? mosi_s : miso_s;
  // A half bit lasts half the prescale times rate plus one
  assign half_end = (clock_prescale[7:1] == 7'h00) ? 7'h00 :
                    clock_prescale[7:1] - 7'h01;
  assign tick = (pre_cnt == half_end) && (scr_cnt == scr);
  assign busy = (state != sspc_pkg::SSPC_IDLE) || slv_on;
  assign wa = awaddr_q & sspc_pkg::WORD_MASK;
  assign ra = s_axi_araddr_i & sspc_pkg::WORD_MASK;

  always_comb
  begin
    status = '0;
    status[sspc_pkg::ST_TX_EMPTY] = (tx_cnt == '0);
    status[sspc_pkg::ST_TX_NOT_FULL] = (tx_cnt != DEPTH_C);
    status[sspc_pkg::ST_RX_NOT_EMPTY] = (rx_cnt != '0);
    status[sspc_pkg::ST_RX_FULL] = (rx_cnt == DEPTH_C);
    status[sspc_pkg::ST_BUSY] = busy;
    raw = '0;
    raw[sspc_pkg::IRQ_OVERRUN] = overrun;
    raw[sspc_pkg::IRQ_RX_HALF] = (rx_cnt >= HALF_C);
    raw[sspc_pkg::IRQ_TX_HALF] = (tx_cnt <= HALF_C);
  end

  assign s_axi_awready_o = ~aw_held & ~bvalid;
  assign s_axi_wready_o = ~w_held & ~bvalid;
  assign s_axi_arready_o = ~rvalid;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;

  // Both ends share one shift register; only one role is live at a time
  assign serial_clk_o = sclk_q;
  assign serial_clk_oe_o = master_on;
  assign frame_sync_line_o = sel_q;
  assign frame_sync_line_oe_o = master_on;
  assign mosi_o = tx_sh[FRAME_W-1];
  assign mosi_oe_o = master_on;
  assign miso_o = tx_sh[FRAME_W-1];
  assign miso_oe_o = slave_mode & (is_ssi ? slv_on : ~sel_s);

  ////////////////////////////////////////////////////////////////////////////
  // Pins are async to the core clock; the master also samples MISO late,
  // so the half bit must span at least three core cycles
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      {sclk_m, sclk_s, sclk_d} <= 3'h0;
      {sel_m, sel_s, mosi_m, mosi_s, miso_m, miso_s} <= 6'h00;
    end
    else
    begin
      sclk_m <= serial_clk_i;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      sel_m <= frame_sync_line_i;
      sel_s <= sel_m;
      mosi_m <= mosi_i;
      mosi_s <= mosi_m;
      miso_m <= miso_i;
      miso_s <= miso_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    next_control_zero = control_zero;
    next_control_one = control_one;
    next_clock_prescale = clock_prescale;
    next_irq_mask = irq_mask;
    next_overrun = overrun;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_state = state;
    next_pre_cnt = pre_cnt;
    next_scr_cnt = scr_cnt;
    next_edge_cnt = edge_cnt;
    next_tx_sh = tx_sh;
    next_rx_sh = rx_sh;
    next_sclk_q = sclk_q;
    next_sel_q = sel_q;
    next_slv_on = slv_on;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    tx_wdata = wdata_q[FRAME_W-1:0];
    rx_wdata = rx_sh;
    edge_go = 1'b0;
    slv_done = 1'b0;
    slv_load = 1'b0;
    rd_val = 32'h0000_0000;
    wr_val = 32'h0000_0000;
    rd_hit = 1'b1;

    // Write side: address and data are held until both are present
    if (s_axi_awvalid_i && s_axi_awready_o)
    begin
      next_aw_held = 1'b1;
      next_awaddr_q = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o)
    begin
      next_w_held = 1'b1;
      next_wdata_q = s_axi_wdata_i;
      next_wstrb_q = s_axi_wstrb_i;
    end
    if (bvalid && s_axi_bready_i)
    begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !bvalid)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = sspc_pkg::RESP_OKAY;
      if (wa == sspc_pkg::OFF_CONTROL_ZERO)
      begin
        wr_val = merge(32'(control_zero), wdata_q, wstrb_q);
        next_control_zero = wr_val[sspc_pkg::CR0_W-1:0];
      end
      else if (wa == sspc_pkg::OFF_CONTROL_ONE)
      begin
        wr_val = merge(32'(control_one), wdata_q, wstrb_q);
        next_control_one = wr_val[sspc_pkg::CR1_W-1:0];
      end
      else if (wa == sspc_pkg::OFF_FIFO_DATA_PORT)
      begin
        // A write into a full FIFO is dropped
        tx_push = (|wstrb_q) && (tx_cnt != DEPTH_C);
      end
      else if (wa == sspc_pkg::OFF_CLOCK_PRESCALE)
      begin
        wr_val = merge(32'(clock_prescale), wdata_q, wstrb_q);
        next_clock_prescale = wr_val[sspc_pkg::PRESCALE_W-1:0];
      end
      else if (wa == sspc_pkg::OFF_IRQ_MASK)
      begin
        wr_val = merge(32'(irq_mask), wdata_q, wstrb_q);
        next_irq_mask = wr_val[sspc_pkg::IRQ_W-1:0];
      end
      else if (wa == sspc_pkg::OFF_IRQ_CLEAR)
      begin
        if (wdata_q[sspc_pkg::IRQ_OVERRUN])
        begin
          next_overrun = 1'b0;
        end
      end
      else if (wa != sspc_pkg::OFF_PORT_STATUS &&
               wa != sspc_pkg::OFF_IRQ_RAW_STATUS &&
               wa != sspc_pkg::OFF_IRQ_MASKED_STATUS)
      begin
        next_bresp = sspc_pkg::RESP_SLVERR;
      end
    end

    // Read side: answer one cycle after the address is taken
    if (ra == sspc_pkg::OFF_CONTROL_ZERO)
      rd_val = 32'(control_zero);
    else if (ra == sspc_pkg::OFF_CONTROL_ONE)
      rd_val = 32'(control_one);
    else if (ra == sspc_pkg::OFF_FIFO_DATA_PORT)
      rd_val = (rx_cnt != '0) ? 32'(rx_mem[rx_rp]) : 32'h0000_0000;
    else if (ra == sspc_pkg::OFF_PORT_STATUS)
      rd_val = 32'(status);
    else if (ra == sspc_pkg::OFF_CLOCK_PRESCALE)
      rd_val = 32'(clock_prescale);
    else if (ra == sspc_pkg::OFF_IRQ_MASK)
      rd_val = 32'(irq_mask);
    else if (ra == sspc_pkg::OFF_IRQ_RAW_STATUS)
      rd_val = 32'(raw);
    else if (ra == sspc_pkg::OFF_IRQ_MASKED_STATUS)
      rd_val = 32'(raw & irq_mask);
    else if (ra != sspc_pkg::OFF_IRQ_CLEAR)
      rd_hit = 1'b0;
    if (rvalid && s_axi_rready_i)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = rd_hit ? sspc_pkg::RESP_OKAY : sspc_pkg::RESP_SLVERR;
      rx_pop = (ra == sspc_pkg::OFF_FIFO_DATA_PORT) && (rx_cnt != '0);
    end

    // Master bit timer runs only while a frame is under way
    if (state == sspc_pkg::SSPC_IDLE || tick)
    begin
      next_pre_cnt = 7'h00;
      next_scr_cnt = 8'h00;
    end
    else if (pre_cnt == half_end)
    begin
      next_pre_cnt = 7'h00;
      next_scr_cnt = scr_cnt + 8'h01;
    end
    else
    begin
      next_pre_cnt = pre_cnt + 7'h01;
    end

    case (state)
      sspc_pkg::SSPC_IDLE:
      begin
        next_sclk_q = clock_idle_polarity;
        next_sel_q = ~is_ssi;
        if (master_on && tx_cnt != '0)
        begin
          tx_pop = 1'b1;
          next_tx_sh = tx_mem[tx_rp] << (4'(FRAME_W - 1) - data_size_field);
          next_rx_sh = '0;
          next_edge_cnt = 6'h00;
          next_sel_q = is_ssi;
          next_state = sspc_pkg::SSPC_LEAD;
        end
      end
      sspc_pkg::SSPC_LEAD:
      begin
        if (tick)
        begin
          next_state = sspc_pkg::SSPC_RUN;
        end
      end
      sspc_pkg::SSPC_RUN:
      begin
        if (tick)
        begin
          next_sclk_q = ~sclk_q;
          next_edge_cnt = edge_cnt + 6'h01;
          edge_go = (edge_cnt >= prefix);
          // Synchronous serial sync is a one-bit pulse ahead of the data
          if (is_ssi && edge_cnt == prefix - 6'h01)
          begin
            next_sel_q = 1'b0;
          end
          if (edge_cnt == frame_edges + prefix - 6'h01)
          begin
            next_state = sspc_pkg::SSPC_TAIL;
          end
        end
      end
      sspc_pkg::SSPC_TAIL:
      begin
        if (tick)
        begin
          next_sel_q = ~is_ssi;
          rx_push = 1'b1;
          next_state = sspc_pkg::SSPC_IDLE;
        end
      end
      default:
      begin
        next_state = sspc_pkg::SSPC_IDLE;
      end
    endcase

    // Slave: frame sync decides when MOSI carries data
    if (!slave_mode)
    begin
      next_slv_on = 1'b0;
    end
    else if (!slv_on)
    begin
      slv_load = is_ssi ? (sclk_s != sclk_d && !sclk_s && sel_s) :
                 !sel_s;
      next_slv_on = slv_load;
    end
    else if (!is_ssi && sel_s)
    begin
      next_slv_on = 1'b0;
    end
    else if (sclk_s != sclk_d)
    begin
      edge_go = 1'b1;
      next_edge_cnt = edge_cnt + 6'h01;
      slv_done = (edge_cnt == frame_edges - 6'h01);
    end

    if (edge_go)
    begin
      if (capture_now)
      begin
        next_rx_sh = {rx_sh[FRAME_W-2:0], in_bit};
      end
      else if (d_idx != 6'h00)
      begin
        next_tx_sh = tx_sh << 1;
      end
    end
    if (slv_done)
    begin
      rx_push = 1'b1;
      rx_wdata = next_rx_sh;
      next_slv_on = ~is_ssi;
      slv_load = ~is_ssi;
    end
    if (slv_load)
    begin
      // Nothing queued: the slave answers with zeros
      tx_pop = (tx_cnt != '0);
      next_tx_sh = (tx_cnt != '0) ?
                   tx_mem[tx_rp] << (4'(FRAME_W - 1) - data_size_field) : '0;
      next_rx_sh = '0;
      next_edge_cnt = 6'h00;
    end

    rx_accept = rx_push && (rx_cnt != DEPTH_C || rx_pop);
    if (rx_push && !rx_accept)
    begin
      next_overrun = 1'b1;
    end
    next_tx_cnt = tx_cnt + CNT_W'(tx_push) - CNT_W'(tx_pop);
    next_rx_cnt = rx_cnt + CNT_W'(rx_accept) - CNT_W'(rx_pop);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i)
  begin
    if (tx_push)
      tx_mem[tx_wp] <= tx_wdata;
    if (rx_accept)
      rx_mem[rx_wp] <= rx_wdata;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      control_zero <= sspc_pkg::CR0_RESET;
      control_one <= sspc_pkg::CR1_RESET;
      clock_prescale <= sspc_pkg::PRESCALE_RESET;
      irq_mask <= sspc_pkg::MASK_RESET;
      overrun <= 1'b0;
      {aw_held, w_held, bvalid, rvalid} <= 4'h0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bresp <= sspc_pkg::RESP_OKAY;
      rresp <= sspc_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      {tx_wp, tx_rp, rx_wp, rx_rp} <= '0;
      tx_cnt <= '0;
      rx_cnt <= '0;
      state <= sspc_pkg::SSPC_IDLE;
      pre_cnt <= 7'h00;
      scr_cnt <= 8'h00;
      edge_cnt <= 6'h00;
      tx_sh <= '0;
      rx_sh <= '0;
      sclk_q <= 1'b0;
      sel_q <= 1'b1;
      slv_on <= 1'b0;
    end
    else
    begin
      control_zero <= next_control_zero;
      control_one <= next_control_one;
      clock_prescale <= next_clock_prescale;
      irq_mask <= next_irq_mask;
      overrun <= next_overrun;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      bvalid <= next_bvalid;
      rvalid <= next_rvalid;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      bresp <= next_bresp;
      rresp <= next_rresp;
      rdata <= next_rdata;
      tx_wp <= tx_push ? bump(tx_wp) : tx_wp;
      tx_rp <= tx_pop ? bump(tx_rp) : tx_rp;
      rx_wp <= rx_accept ? bump(rx_wp) : rx_wp;
      rx_rp <= rx_pop ? bump(rx_rp) : rx_rp;
      tx_cnt <= next_tx_cnt;
      rx_cnt <= next_rx_cnt;
      state <= next_state;
      pre_cnt <= next_pre_cnt;
      scr_cnt <= next_scr_cnt;
      edge_cnt <= next_edge_cnt;
      tx_sh <= next_tx_sh;
      rx_sh <= next_rx_sh;
      sclk_q <= next_sclk_q;
      sel_q <= next_sel_q;
      slv_on <= next_slv_on;
    end
  end

endmodule : sspc_top

/* tb/sspc_sva.sv */
`timescale 1ns/10ps
module sspc_sva (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic serial_clk_oe_o,
  input wire logic frame_sync_line_oe_o,
  input wire logic miso_oe_o,
  input wire logic mosi_oe_o
);
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_b_wait;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence
  sequence s_r_wait;
    s_axi_rvalid_o && !s_axi_rready_i;
  endsequence
  a_w_refused: assert property (s_axi_bvalid_o |->
    !s_axi_awready_o && !s_axi_wready_o) else $error("write taken early");
  a_b_stands: assert property (s_b_wait |=> s_axi_bvalid_o)
    else $error("write answer dropped");
  a_b_clears: assert property (s_axi_bvalid_o && s_axi_bready_i |=>
    !s_axi_bvalid_o) else $error("write answer repeated");
  a_r_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken early");
  a_r_stands: assert property (s_r_wait |=> s_axi_rvalid_o)
    else $error("read answer dropped");
  a_r_clears: assert property (s_axi_rvalid_o && s_axi_rready_i |=>
    !s_axi_rvalid_o) else $error("read answer repeated");
  a_master_pins: assert property (serial_clk_oe_o == mosi_oe_o
    && serial_clk_oe_o == frame_sync_line_oe_o) else $error("pins split");
  a_miso_master: assert property (serial_clk_oe_o |-> !miso_oe_o)
    else $error("master drives miso");
endmodule : sspc_sva
bind sspc_top sspc_sva u_sva (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .serial_clk_oe_o(serial_clk_oe_o),
  .frame_sync_line_oe_o(frame_sync_line_oe_o), .miso_oe_o(miso_oe_o),
  .mosi_oe_o(mosi_oe_o));

/* tb/sspc_peer.sv */
`timescale 1ns/10ps
module sspc_peer (
  input wire logic sclk_i,
  input wire logic sel_i,
  input wire logic mosi_i,
  input wire logic [4:0] bits_i,
  input wire logic [15:0] tx_i,
  output logic miso_o,
  output logic [15:0] rx_o
);
  logic [15:0] sh = 16'h0;
  logic last = 1'b0;
  // Released line shows the inverse, so a stale bit never passes
  assign miso_o = sel_i ? ~last : sh[bits_i - 5'd1];
  always @(negedge sel_i) sh = tx_i;
  always @(posedge sel_i) last = sh[bits_i - 5'd1];
  always @(posedge sclk_i) if (!sel_i) rx_o = {rx_o[14:0], mosi_i};
  always @(negedge sclk_i) if (!sel_i) sh = sh << 1;
endmodule : sspc_peer

/* tb/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic core_clk_i = 0, rst_i = 1, lc = 0, ls = 1, lm = 0, cp = 0, da, dw;
  logic [11:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, d, w, t, m;
  logic [3:0] s_axi_wstrb_i = 4'hf, c;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
  logic s_axi_arvalid_i = 0, s_axi_rready_i = 0, s_axi_awready_o, pm;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic serial_clk_o, serial_clk_oe_o, frame_sync_line_o, miso_o, mosi_o;
  logic frame_sync_line_oe_o, miso_oe_o, mosi_oe_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rs, f;
  logic [15:0] ptx, prx, g;
  integer err_total = 0, total_checks = 0, cyc = 0, i, k;
  integer seed = 32'hf914_452b;
  wire serial_clk_i = serial_clk_oe_o ? serial_clk_o : lc;
  wire frame_sync_line_i = frame_sync_line_oe_o ? frame_sync_line_o : ls;
  wire mosi_i = mosi_oe_o ? mosi_o : lm;
  wire miso_i = miso_oe_o ? miso_o : pm;
  sspc_top dut_u (.*);
  sspc_peer peer_u (.sclk_i(serial_clk_i ^ cp), .sel_i(frame_sync_line_i),
    .mosi_i(mosi_i), .bits_i({1'b0, c} + 5'h1), .tx_i(ptx), .miso_o(pm),
    .rx_o(prx));
  always #2.5 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////
  function automatic logic [31:0] msk(input logic [31:0] v);
    return v & ((32'h1 << (c + 1)) - 32'h1);
  endfunction : msk
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic ck(input logic [31:0] gv, input logic [31:0] ev);
    total_checks++;
    if (gv !== ev)
    begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, gv, ev);
    end
  endtask : ck
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    da = 0;
    dw = 0;
    while (!(da && dw))
    begin
      @(negedge core_clk_i);
      da = da || s_axi_awready_o;
      dw = dw || s_axi_wready_o;
      @(posedge core_clk_i);
      if (da) s_axi_awvalid_i <= 0;
      if (dw) s_axi_wvalid_i <= 0;
    end
    do @(negedge core_clk_i); while (!s_axi_bvalid_o);
    rs = s_axi_bresp_o;
    // Late bready keeps the answer standing for one edge
    @(posedge core_clk_i);
    s_axi_bready_i <= 1;
    @(posedge core_clk_i);
    s_axi_bready_i <= 0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    do @(negedge core_clk_i); while (!s_axi_arready_o);
    @(posedge core_clk_i);
    s_axi_arvalid_i <= 0;
    do @(negedge core_clk_i); while (!s_axi_rvalid_o);
    d = s_axi_rdata_o;
    rs = s_axi_rresp_o;
    @(posedge core_clk_i);
    s_axi_rready_i <= 1;
    @(posedge core_clk_i);
    s_axi_rready_i <= 0;
  endtask : rd
  task automatic ws(input logic [31:0] x);
    do rd(12'h00c); while (d !== x);
  endtask : ws
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      stop_test;
    end
  end
  ////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    rst_i <= 0;
    @(posedge core_clk_i);
    for (i = 0; i < 9; i++)
    begin
      rd(12'(i * 4));
      ck(d, (i == 3) ? 32'h3 : (i == 6) ? 32'h8 : 32'h0);
    end
    rd(12'h024);
    ck({30'h0, rs}, 32'h2);
    wr(12'h024, 32'h1);
    ck({30'h0, rs}, 32'h2);
    m = $random(seed) & 32'hf;
    wr(12'h014, m);
    ck({30'h0, rs}, 32'h0);
    rd(12'h01c);
    ck(d, m & 32'h8);
    w = $random(seed) & 32'hff;
    wr(12'h010, w);
    rd(12'h010);
    ck(d, w);
    wr(12'h010, 32'h8);
    wr(12'h004, 32'h2);
    $display("register test done");
    for (k = 0; k < 6; k++)
    begin
      f = 2'(k % 3);
      c = (k == 0) ? 4'h3 : (k == 2) ? 4'hf : 4'(3 + {$random(seed)} % 13);
      cp = (f == 0) ? 1'($random(seed)) : 1'b0;
      ptx = 16'($random(seed));
      w = $random(seed);
      wr(12'h000, {16'h0, 8'h1, 1'b0, cp, f, c});
      wr(12'h008, w);
      ws(32'h7);
      rd(12'h008);
      if (f != 2'h1)
      begin
        ck(d, msk({16'h0, ptx}));
        ck(msk({16'h0, prx}), msk(w));
      end
      ck({31'h0, frame_sync_line_o}, {31'h0, f != 2'h1});
      ck({31'h0, serial_clk_o}, {31'h0, cp});
    end
    $display("frame test done");
    wr(12'h004, 32'h0);
    c = 4'hf;
    cp = 0;
    wr(12'h000, 32'h010f);
    for (i = 0; i < 9; i++) wr(12'h008, 32'(i));
    rd(12'h00c);
    ck(d, 32'h0);
    wr(12'h004, 32'h2);
    ws(32'hf);
    wr(12'h008, 32'h9);
    ws(32'hf);
    rd(12'h018);
    ck(d, 32'hd);
    wr(12'h020, 32'h1);
    rd(12'h01c);
    ck(d, m & 32'hc);
    for (i = 0; i < 8; i++)
    begin
      rd(12'h008);
      ck(d, {16'h0, ptx});
    end
    rd(12'h00c);
    ck(d, 32'h3);
    $display("fifo test done");
    wr(12'h004, 32'h6);
    c = 4'h7;
    wr(12'h000, 32'h0007);
    t = $random(seed) & 32'hff;
    w = $random(seed) & 32'hff;
    wr(12'h008, t);
    ck({31'h0, miso_oe_o}, 32'h0);
    #1.3 ls = 0;
    #40;
    for (i = 7; i >= 0; i--)
    begin
      lm = w[i];
      #32 lc = 1;
      g[i] = miso_i;
      #32 lc = 0;
    end
    ck({31'h0, miso_oe_o}, 32'h1);
    #40 ls = 1;
    @(posedge core_clk_i);
    ck({24'h0, g[7:0]}, t);
    rd(12'h008);
    ck(d, w);
    ck({31'h0, miso_oe_o}, 32'h0);
    $display("slave test done");
    stop_test;
  end
endmodule : tb_top
